// ==== core/cfgsig_pkg.sv ====
// Constants shared by the configuration and signature read-out ends.
// Assumes a single 200 MHz clock and two synchronous resets, srst and por_rst.
package cfgsig_pkg;
	// Programming control register bit positions
	localparam int unsigned SELF_PROG_EN_BIT = 0;
	localparam int unsigned PAGE_ERASE_BIT = 1;
	localparam int unsigned PAGE_WRITE_BIT = 2;
	localparam int unsigned CONFIG_READ_BIT = 3;
	localparam int unsigned CLR_BUF_BIT = 4;
	localparam int unsigned SIG_ROW_READ_BIT = 5;
	localparam int unsigned RWW_BUSY_BIT = 6;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	// Accepted control write patterns
	localparam logic [5:0] CTRL_SIG_READ = 6'h21;
	localparam logic [5:0] CTRL_CLR_BUF = 6'h11;
	localparam logic [5:0] CTRL_CFG_READ = 6'h09;
	localparam logic [5:0] CTRL_PAGE_WRITE = 6'h05;
	localparam logic [5:0] CTRL_PAGE_ERASE = 6'h03;
	localparam logic [5:0] CTRL_FILL = 6'h01;
	// Arming windows, in cycles after the control write
	localparam logic [2:0] LOAD_WIN = 3'h3;
	localparam logic [2:0] STORE_WIN = 3'h4;
	// Index pointer addresses for configuration reads
	localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
	localparam logic [15:0] Z_LOCK = 16'h0001;
	localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
	localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
	// Signature row addresses
	localparam logic [15:0] Z_SIG_ID0 = 16'h0000;
	localparam logic [15:0] Z_SIG_CAL = 16'h0001;
	localparam logic [15:0] Z_SIG_ID1 = 16'h0002;
	localparam logic [15:0] Z_SIG_TS_OFS = 16'h0003;
	localparam logic [15:0] Z_SIG_ID2 = 16'h0004;
	localparam logic [15:0] Z_SIG_TS_GAIN = 16'h0005;
	localparam logic [7:0] SIG_RESERVED = 8'hFF;
	// Flash write time
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam longint unsigned FLASH_WR_MIN_NS = 3700000;
	localparam longint unsigned FLASH_WR_MAX_NS = 4500000;
	localparam int unsigned FLASH_WR_CYC = int'((FLASH_WR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int unsigned FLASH_CNT_W = 20;
	// Flash operation kinds
	typedef enum logic [1:0] {
		CFGSIG_FL_ERASE = 2'h0,
		CFGSIG_FL_WRITE = 2'h1,
		CFGSIG_FL_LOCK = 2'h2,
		CFGSIG_FL_FILL = 2'h3
	} cfgsig_flop_t;
	// Controller commands
	typedef enum logic [2:0] {
		CFGSIG_OP_LOAD = 3'h0,
		CFGSIG_OP_CFG = 3'h1,
		CFGSIG_OP_SIG = 3'h2,
		CFGSIG_OP_ERASE = 3'h3,
		CFGSIG_OP_WRITE = 3'h4,
		CFGSIG_OP_FILL = 3'h5
	} cfgsig_op_t;
	// Controller APB register offsets
	localparam logic [7:0] HOST_ADDR_OFS = 8'h00;
	localparam logic [7:0] HOST_CMD_OFS = 8'h04;
	localparam logic [7:0] HOST_RESULT_OFS = 8'h08;
	localparam int unsigned RESULT_DONE_BIT = 8;
endpackage

// ==== core/cfgsig_if.sv ====
// Link between the core-side loader and the read-out device.
// Both ends run on the same clk; no timing of its own.
`timescale 1ns/1ps
interface cfgsig_if;
	logic ctrl_wr;
	logic [7:0] ctrl_wdata;
	logic [7:0] ctrl_rdata;
	logic [15:0] zptr;
	logic load_req;
	logic load_ack;
	logic [7:0] load_data;
	logic store_req;
	logic ee_busy;
	modport dev (input ctrl_wr, ctrl_wdata, zptr, load_req, store_req,
		output ctrl_rdata, load_ack, load_data, ee_busy);
	modport host (output ctrl_wr, ctrl_wdata, zptr, load_req, store_req,
		input ctrl_rdata, load_ack, load_data, ee_busy);
endinterface

// ==== core/cfgsig_dev.sv ====
// Configuration and signature read-out device end.
// Assumes latched fuse and lock copies and a combinational program memory read port.
// Contract
// - Pointer 1 armed load returns lock bits
// - Clear read flags on completion or timeout
// - Disarmed load reads program memory normally
// - Pointer 0 armed load returns low fuses
// - Pointer 3 armed load returns high fuses
// - Pointer 2 returns extended fuse byte
// - Programmed bits read zero, unprogrammed one
// - Signature armed load returns signature byte
// - Clear signature flags on completion or timeout
// - Identity bytes at pointers 0, 2, 4
// - Calibration 1, sensor offset 3, gain 5
// - Software ignores reserved signature addresses
// - Reset never aborts a running flash write; por_rst here does
// - Flash writes last 3.7 to 4.5 ms
// - Read-while-write busy always reads zero
// - Loader polls enable flag before commands
// - Loader masks interrupts, waits EEPROM idle
// - Signature read flag is control bit 5
// - Config read flag is control bit 3
// - Enable flag is bit 0, arms window
// - EEPROM write blocks config reads, programming
`timescale 1ns/1ps
module cfgsig_dev #(
	parameter int unsigned FLASH_WR_CYC = cfgsig_pkg::FLASH_WR_CYC, // Flash write duration in clocks
	parameter logic [7:0] SIG_ID0 = 8'h5A, // Identity byte 0, arbitrary value
	parameter logic [7:0] SIG_ID1 = 8'hA5, // Identity byte 1, arbitrary value
	parameter logic [7:0] SIG_ID2 = 8'h3C // Identity byte 2, arbitrary value
) (
	input wire logic clk, // System clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic por_rst, // Power-on reset, clears everything
	cfgsig_if.dev lnk, // Link to the loader
	input wire logic [1:0] lock_bits, // Latched lock bits, 0 = programmed
	input wire logic [7:0] fuse_low_config_byte, // Latched low fuse byte
	input wire logic [7:0] fuse_high_config_byte, // Latched high fuse byte
	input wire logic fuse_ext_bit, // Latched extended fuse bit 0
	input wire logic [7:0] osc_cal_byte, // Oscillator calibration byte
	input wire logic [7:0] temp_sensor_offset_byte, // Temperature sensor offset
	input wire logic [7:0] temp_sensor_gain_byte, // Temperature sensor gain
	input wire logic eeprom_write_in_progress_flag, // EEPROM write running
	output logic [15:0] prog_rd_addr, // Program memory byte address
	input wire logic [7:0] prog_rd_data, // Program memory byte read data
	output logic flash_start, // One-cycle pulse: flash operation begins
	output cfgsig_pkg::cfgsig_flop_t flash_kind, // Kind of the last flash operation
	output logic flash_busy // Timed flash write running
);
	import cfgsig_pkg::*;

	logic [5:0] prog_ctrl_status_reg_q;
	logic [5:0] ctrl_d;
	logic [2:0] win_q;
	logic [FLASH_CNT_W-1:0] fl_cnt_q;
	logic fl_busy_q;
	logic ack_q;
	logic [7:0] data_q;
	logic start_q;
	cfgsig_flop_t kind_q;

	wire self_prog_enable_flag = prog_ctrl_status_reg_q[SELF_PROG_EN_BIT];
	wire config_read_flag = prog_ctrl_status_reg_q[CONFIG_READ_BIT];
	wire sig_row_read_flag = prog_ctrl_status_reg_q[SIG_ROW_READ_BIT];
	wire erase_flag = prog_ctrl_status_reg_q[PAGE_ERASE_BIT];
	wire write_flag = prog_ctrl_status_reg_q[PAGE_WRITE_BIT];
	wire read_while_write_busy_flag = 1'b0;
	wire ee_block = eeprom_write_in_progress_flag;

	// Control writes that match a legal pattern
	wire wr_pattern_ok = (lnk.ctrl_wdata[5:0] == CTRL_SIG_READ) || (lnk.ctrl_wdata[5:0] == CTRL_CLR_BUF) ||
		(lnk.ctrl_wdata[5:0] == CTRL_CFG_READ) || (lnk.ctrl_wdata[5:0] == CTRL_PAGE_WRITE) ||
		(lnk.ctrl_wdata[5:0] == CTRL_PAGE_ERASE) || (lnk.ctrl_wdata[5:0] == CTRL_FILL);
	// A pending arm must not be overwritten while the flash is busy
	wire ctrl_take = lnk.ctrl_wr && wr_pattern_ok && !ee_block && !fl_busy_q;

	wire load_win = win_q < LOAD_WIN;
	wire store_win = win_q < STORE_WIN;
	wire cfg_armed = self_prog_enable_flag && config_read_flag && load_win && !ee_block;
	wire sig_armed = self_prog_enable_flag && sig_row_read_flag && load_win;
	wire load_cfg = lnk.load_req && cfg_armed;
	wire load_sig = lnk.load_req && sig_armed;
	wire read_mode = config_read_flag || sig_row_read_flag;
	wire store_take = lnk.store_req && self_prog_enable_flag && store_win && !fl_busy_q && !ee_block
		&& !sig_row_read_flag;
	wire timed_op = erase_flag || write_flag || config_read_flag;
	wire store_timed = store_take && timed_op;
	wire fl_done = fl_busy_q && (fl_cnt_q == FLASH_CNT_W'(FLASH_WR_CYC - 1));
	wire read_expire = read_mode && !fl_busy_q && (win_q == LOAD_WIN - 3'h1) && !lnk.load_req;
	wire store_expire = !read_mode && !fl_busy_q && (win_q == STORE_WIN - 3'h1) && !lnk.store_req;

	// Fuse and lock view; unprogrammed unused bits read as one
	wire [7:0] lock_byte = {6'h3F, lock_bits};
	wire [7:0] ext_byte = {7'h7F, fuse_ext_bit};
	wire [7:0] cfg_byte = (lnk.zptr == Z_LOCK) ? lock_byte :
		(lnk.zptr == Z_FUSE_LOW) ? fuse_low_config_byte :
		(lnk.zptr == Z_FUSE_EXT) ? ext_byte :
		(lnk.zptr == Z_FUSE_HIGH) ? fuse_high_config_byte :
		8'hFF;
	wire [7:0] sig_byte = (lnk.zptr == Z_SIG_ID0) ? SIG_ID0 :
		(lnk.zptr == Z_SIG_ID1) ? SIG_ID1 :
		(lnk.zptr == Z_SIG_ID2) ? SIG_ID2 :
		(lnk.zptr == Z_SIG_CAL) ? osc_cal_byte :
		(lnk.zptr == Z_SIG_TS_OFS) ? temp_sensor_offset_byte :
		(lnk.zptr == Z_SIG_TS_GAIN) ? temp_sensor_gain_byte :
		SIG_RESERVED;
	// One destination path for every load
	wire [7:0] load_byte = load_cfg ? cfg_byte : load_sig ? sig_byte : prog_rd_data;

	always_comb begin
		ctrl_d = prog_ctrl_status_reg_q;
		if (ctrl_take) begin
			ctrl_d = lnk.ctrl_wdata[5:0];
		end else if (fl_done) begin
			ctrl_d = CTRL_RESET;
		end else if (load_cfg || load_sig) begin
			ctrl_d = CTRL_RESET;
		end else if (store_take && !store_timed) begin
			ctrl_d = CTRL_RESET;
		end else if (store_timed) begin
			ctrl_d = prog_ctrl_status_reg_q;
		end else if (read_expire || store_expire) begin
			ctrl_d = CTRL_RESET;
		end
	end

	// Control state; srst during a flash write leaves it untouched, por_rst clears it
	always_ff @(posedge clk) begin
		if (por_rst || (srst && !fl_busy_q)) begin
			prog_ctrl_status_reg_q <= CTRL_RESET;
			win_q <= STORE_WIN;
		end else begin
			prog_ctrl_status_reg_q <= ctrl_d;
			if (ctrl_take) begin
				win_q <= 3'h0;
			end else if (win_q != STORE_WIN) begin
				win_q <= win_q + 3'h1;
			end
		end
	end

	// Flash write timer runs from clk; only power-on stops it
	always_ff @(posedge clk) begin
		if (por_rst) begin
			fl_busy_q <= 1'b0;
			fl_cnt_q <= '0;
		end else if (store_timed) begin
			fl_busy_q <= 1'b1;
			fl_cnt_q <= '0;
		end else if (fl_done) begin
			fl_busy_q <= 1'b0;
		end else if (fl_busy_q) begin
			fl_cnt_q <= fl_cnt_q + FLASH_CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst || por_rst) begin
			ack_q <= 1'b0;
			data_q <= 8'h00;
			start_q <= 1'b0;
			kind_q <= CFGSIG_FL_ERASE;
		end else begin
			ack_q <= lnk.load_req;
			if (lnk.load_req) begin
				data_q <= load_byte;
			end
			// A lock write (config read flag with a store) starts the flash as well
			start_q <= store_take;
			if (store_take) begin
				kind_q <= erase_flag ? CFGSIG_FL_ERASE : write_flag ? CFGSIG_FL_WRITE :
					config_read_flag ? CFGSIG_FL_LOCK : CFGSIG_FL_FILL;
			end
		end
	end

	assign lnk.ctrl_rdata = {1'b0, read_while_write_busy_flag, prog_ctrl_status_reg_q};
	assign lnk.load_ack = ack_q;
	assign lnk.load_data = data_q;
	assign lnk.ee_busy = eeprom_write_in_progress_flag;
	assign prog_rd_addr = lnk.zptr;
	assign flash_start = start_q;
	assign flash_kind = kind_q;
	assign flash_busy = fl_busy_q;
endmodule // cfgsig_dev

// ==== core/cfgsig_host.sv ====
// Loader end: runs one timed read-out or programming sequence per APB command.
// Assumes the device answers loads one cycle after the request.
`timescale 1ns/1ps
module cfgsig_host (
	input wire logic clk, // System clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic int_block, // High while interrupts must stay masked
	cfgsig_if.host lnk // Link to the device
);
	import cfgsig_pkg::*;

	typedef enum logic [2:0] {
		CFGSIG_ST_IDLE = 3'b000,
		CFGSIG_ST_POLL = 3'b001,
		CFGSIG_ST_WAIT_EE = 3'b011,
		CFGSIG_ST_WRITE = 3'b010,
		CFGSIG_ST_ISSUE = 3'b110,
		CFGSIG_ST_WAIT_RSP = 3'b111
	} cfgsig_st_t;

	cfgsig_st_t st_q;
	cfgsig_st_t st_d;
	logic [15:0] addr_q;
	cfgsig_op_t op_q;
	logic [7:0] result_q;
	logic done_q;

	wire acc = psel && penable;
	wire hit_addr = paddr == HOST_ADDR_OFS;
	wire hit_cmd = paddr == HOST_CMD_OFS;
	wire hit_res = paddr == HOST_RESULT_OFS;
	wire mapped = hit_addr || hit_cmd || hit_res;
	wire idle = st_q == CFGSIG_ST_IDLE;
	// Commands written while busy are dropped
	wire cmd_go = acc && pwrite && hit_cmd && idle;
	wire is_load = op_q inside {CFGSIG_OP_LOAD, CFGSIG_OP_CFG, CFGSIG_OP_SIG};
	wire [5:0] ctrl_val = (op_q == CFGSIG_OP_CFG) ? CTRL_CFG_READ :
		(op_q == CFGSIG_OP_SIG) ? CTRL_SIG_READ :
		(op_q == CFGSIG_OP_ERASE) ? CTRL_PAGE_ERASE :
		(op_q == CFGSIG_OP_WRITE) ? CTRL_PAGE_WRITE : CTRL_FILL;
	wire prev_busy = lnk.ctrl_rdata[SELF_PROG_EN_BIT];

	always_comb begin
		st_d = st_q;
		case (st_q)
			CFGSIG_ST_IDLE: begin
				if (cmd_go) begin
					st_d = CFGSIG_ST_POLL;
				end
			end
			CFGSIG_ST_POLL: begin
				if (!prev_busy) begin
					st_d = (op_q == CFGSIG_OP_LOAD) ? CFGSIG_ST_ISSUE : CFGSIG_ST_WAIT_EE;
				end
			end
			CFGSIG_ST_WAIT_EE: begin
				if (!lnk.ee_busy) begin
					st_d = CFGSIG_ST_WRITE;
				end
			end
			CFGSIG_ST_WRITE: begin
				st_d = CFGSIG_ST_ISSUE;
			end
			CFGSIG_ST_ISSUE: begin
				st_d = is_load ? CFGSIG_ST_WAIT_RSP : CFGSIG_ST_IDLE;
			end
			CFGSIG_ST_WAIT_RSP: begin
				if (lnk.load_ack) begin
					st_d = CFGSIG_ST_IDLE;
				end
			end
			default: begin
				st_d = CFGSIG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= CFGSIG_ST_IDLE;
			addr_q <= 16'h0000;
			op_q <= CFGSIG_OP_LOAD;
			result_q <= 8'h00;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (acc && pwrite && hit_addr) begin
				addr_q <= pwdata[15:0];
			end
			if (cmd_go) begin
				op_q <= cfgsig_op_t'(pwdata[2:0]);
				done_q <= 1'b0;
			end else if ((st_q == CFGSIG_ST_WAIT_RSP && lnk.load_ack) || (st_q == CFGSIG_ST_ISSUE && !is_load)) begin
				done_q <= 1'b1;
			end
			if (st_q == CFGSIG_ST_WAIT_RSP && lnk.load_ack) begin
				result_q <= lnk.load_data;
			end
		end
	end

	// Interrupts stay masked from the EEPROM check until the load or store has gone out
	assign int_block = (st_q == CFGSIG_ST_WAIT_EE) || (st_q == CFGSIG_ST_WRITE) || (st_q == CFGSIG_ST_ISSUE);
	assign lnk.ctrl_wr = st_q == CFGSIG_ST_WRITE;
	assign lnk.ctrl_wdata = {2'b00, ctrl_val};
	assign lnk.zptr = addr_q;
	assign lnk.load_req = (st_q == CFGSIG_ST_ISSUE) && is_load;
	assign lnk.store_req = (st_q == CFGSIG_ST_ISSUE) && !is_load;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata = hit_addr ? {16'h0000, addr_q} :
		hit_cmd ? {31'h0, !idle} :
		hit_res ? {23'h0, done_q, result_q} : 32'h0000_0000;
endmodule // cfgsig_host

// ==== sim/cfgsig_monitor.sv ====
// Checker for the link between loader and read-out device.
// Assumes one clock and the synchronous reset shared by both ends.
`timescale 1ns/1ps
module cfgsig_monitor
	import cfgsig_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic ctrl_wr, // Control write strobe
	input wire logic [7:0] ctrl_wdata, // Control write data
	input wire logic [7:0] ctrl_rdata, // Control read-back
	input wire logic [15:0] zptr, // Index pointer
	input wire logic load_req, // Load strobe
	input wire logic load_ack, // Load answer strobe
	input wire logic [7:0] load_data, // Load answer byte
	input wire logic store_req, // Store strobe
	input wire logic ee_busy // EEPROM write running
);
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_load_ack_next: assert property (load_req |=> load_ack) else $error("load not answered next cycle");
	a_ack_has_cause: assert property (load_ack |-> $past(load_req)) else $error("answer without load");
	a_lock_pad_ones: assert property ($past(load_req) && !$past(ee_busy) && $past(ctrl_rdata[5:0]) == CTRL_CFG_READ
		&& $past(zptr) == Z_LOCK |-> load_data[7:2] == 6'h3F) else $error("lock byte padding wrong");
	a_ext_pad_ones: assert property ($past(load_req) && !$past(ee_busy) && $past(ctrl_rdata[5:0]) == CTRL_CFG_READ
		&& $past(zptr) == Z_FUSE_EXT |-> load_data[7:1] == 7'h7F) else $error("ext fuse padding wrong");
	a_rww_reads_zero: assert property (ctrl_rdata[7:6] == 2'h0) else $error("busy bits not zero");
	a_cfg_load_clears: assert property ($past(load_req) && $past(ctrl_rdata[5:0]) == CTRL_CFG_READ
		&& !$past(ee_busy) |-> ctrl_rdata[5:0] == 6'h00) else $error("config flags not cleared");
	a_sig_load_clears: assert property ($past(load_req) && $past(ctrl_rdata[5:0]) == CTRL_SIG_READ
		|-> ctrl_rdata[5:0] == 6'h00) else $error("signature flags not cleared");
	a_cfg_flag_set: assert property (ctrl_wr && ctrl_wdata[5:0] == CTRL_CFG_READ && !ee_busy && !ctrl_rdata[0]
		|=> ctrl_rdata[5:0] == CTRL_CFG_READ) else $error("config flags not at bits 3 and 0");
	a_sig_flag_set: assert property (ctrl_wr && ctrl_wdata[5:0] == CTRL_SIG_READ && !ee_busy && !ctrl_rdata[0]
		|=> ctrl_rdata[5:0] == CTRL_SIG_READ) else $error("signature flags not at bits 5 and 0");

	c_cfg_load: cover property (ctrl_rdata[3] && load_req);
	c_sig_load: cover property (ctrl_rdata[5] && load_req);
	c_store: cover property (store_req);
	c_blocked_load: cover property (ctrl_rdata[3] && load_req && ee_busy);
endmodule // cfgsig_monitor

// ==== sim/cfgsig_bench.sv ====
// Bench for the read-out pair: APB stimulus into the loader, own model of the expected bytes.
// Assumes both ends on one 200 MHz clock; flash time shortened by parameter.
`timescale 1ns/1ps
module cfgsig_bench;
	import cfgsig_pkg::*;
	localparam int unsigned FWC = 20;
	localparam logic [7:0] ID0 = 8'h11; // Arbitrary identity value
	localparam logic [7:0] ID1 = 8'h22; // Arbitrary identity value
	localparam logic [7:0] ID2 = 8'h33; // Arbitrary identity value
	logic clk = 1'h0, srst = 1'h1, por_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ee = 1'h0, fx = 1'h1;
	logic [7:0] paddr = 8'h00, fl = 8'h62, fh = 8'hDF, cal = 8'h80, tso = 8'h10, tsg = 8'h20;
	logic [1:0] lb = 2'h3;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, int_block, e, fstart, fbusy;
	logic [15:0] pa;
	wire logic [7:0] pd;
	cfgsig_flop_t fkind, kind_q;
	int num_errors = 0, compares = 0, starts = 0, busy_cyc = 0;

	// Program memory stand-in: address-dependent so a wrong source shows
	function automatic logic [7:0] pm(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	function automatic logic [7:0] model(input int op, input logic [15:0] z);
		if (op == 0)
			return pm(z);
		if (op == 1)
			return z == 16'h0 ? fl : z == 16'h1 ? {6'h3F, lb} : z == 16'h2 ? {7'h7F, fx} : z == 16'h3 ? fh : 8'hFF;
		return z == 16'h0 ? ID0 : z == 16'h1 ? cal : z == 16'h2 ? ID1 : z == 16'h3 ? tso : z == 16'h4 ? ID2 :
			z == 16'h5 ? tsg : 8'hFF;
	endfunction
	assign pd = pm(pa);

	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (fstart === 1'h1) begin
			starts <= starts + 1;
			kind_q <= fkind;
		end
		if (fbusy === 1'h1)
			busy_cyc <= busy_cyc + 1;
	end

	cfgsig_if lnk();
	cfgsig_dev #(.FLASH_WR_CYC(FWC), .SIG_ID0(ID0), .SIG_ID1(ID1), .SIG_ID2(ID2)) i_cfgsig_dev (.clk(clk),
		.srst(srst), .por_rst(por_rst), .lnk(lnk), .lock_bits(lb), .fuse_low_config_byte(fl),
		.fuse_high_config_byte(fh), .fuse_ext_bit(fx), .osc_cal_byte(cal), .temp_sensor_offset_byte(tso),
		.temp_sensor_gain_byte(tsg), .eeprom_write_in_progress_flag(ee), .prog_rd_addr(pa), .prog_rd_data(pd),
		.flash_start(fstart), .flash_kind(fkind), .flash_busy(fbusy));
	cfgsig_host i_cfgsig_host (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.int_block(int_block), .lnk(lnk));
	cfgsig_monitor i_cfgsig_monitor (.clk(clk), .srst(srst), .ctrl_wr(lnk.ctrl_wr), .ctrl_wdata(lnk.ctrl_wdata),
		.ctrl_rdata(lnk.ctrl_rdata), .zptr(lnk.zptr), .load_req(lnk.load_req), .load_ack(lnk.load_ack),
		.load_data(lnk.load_data), .store_req(lnk.store_req), .ee_busy(lnk.ee_busy));

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			num_errors++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic poll(input int op, input logic [15:0] z);
		int n;
		n = 0;
		r = 32'h0;
		while (r[RESULT_DONE_BIT] !== 1'h1 && n < 50) begin
			apb(1'h0, HOST_RESULT_OFS, 32'h0, r, e);
			n++;
		end
		chk(32'(r[RESULT_DONE_BIT]), 32'h1);
		chk({24'h0, r[7:0]}, {24'h0, model(op, z)});
	endtask
	task automatic run(input int op, input logic [15:0] z);
		apb(1'h1, HOST_ADDR_OFS, {16'h0, z}, r, e);
		apb(1'h1, HOST_CMD_OFS, 32'(op), r, e);
		poll(op, z);
	endtask
	// Erase and write get a reset in mid-operation; the timed write must still run its full length
	task automatic flash(input int op, input cfgsig_flop_t kind);
		int s0, b0, n;
		s0 = starts;
		b0 = busy_cyc;
		n = 0;
		apb(1'h1, HOST_CMD_OFS, 32'(op), r, e);
		while (starts == s0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		chk(32'(kind_q), 32'(kind));
		if (op == 5) begin
			chk(32'(fbusy), 32'h0);
			return;
		end
		// A new command while the flash runs must stall in the poll of the enable flag
		apb(1'h1, HOST_CMD_OFS, 32'h0, r, e);
		apb(1'h0, HOST_CMD_OFS, 32'h0, r, e);
		chk(32'(r[0]), 32'h1);
		chk(32'(lnk.ctrl_rdata[SELF_PROG_EN_BIT]), 32'h1);
		srst <= 1'h1;
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		n = 0;
		while (fbusy !== 1'h0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		chk(32'(busy_cyc - b0), 32'(FWC));
		chk(32'(lnk.ctrl_rdata[SELF_PROG_EN_BIT]), 32'h0);
		apb(1'h0, HOST_CMD_OFS, 32'h0, r, e);
		chk(32'(r[0]), 32'h0);
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		void'($urandom(36137));
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		por_rst <= 1'h0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			{lb, fx, fl, fh} <= 19'($urandom);
			{cal, tso, tsg} <= 24'($urandom);
			for (int op = 0; op < 3; op++) begin
				for (int i = 0; i < 8; i++)
					run(op, i < 6 ? 16'(i) : i == 6 ? 16'(6 + $urandom % 10) : 16'($urandom));
			end
		end
		ee <= 1'h1;
		apb(1'h1, HOST_ADDR_OFS, 32'h0, r, e);
		apb(1'h1, HOST_CMD_OFS, 32'h1, r, e);
		repeat (10) @(posedge clk);
		chk(32'(int_block), 32'h1);
		apb(1'h0, HOST_RESULT_OFS, 32'h0, r, e);
		chk(32'(r[RESULT_DONE_BIT]), 32'h0);
		ee <= 1'h0;
		poll(1, 16'h0000);
		// EEPROM write rising in the load cycle: a plain load, then the read flags time out
		apb(1'h1, HOST_CMD_OFS, 32'h1, r, e);
		@(posedge clk iff lnk.ctrl_wr === 1'h1);
		ee <= 1'h1;
		poll(0, 16'h0000);
		ee <= 1'h0;
		@(posedge clk);
		chk(32'(lnk.ctrl_rdata), 32'h0);
		flash(3, CFGSIG_FL_ERASE);
		flash(4, CFGSIG_FL_WRITE);
		flash(5, CFGSIG_FL_FILL);
		apb(1'h0, 8'h0C, 32'h0, r, e);
		chk(32'(e), 32'h1);
		chk(r, 32'h0);
		finish_test();
	end
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		finish_test();
	end
endmodule // cfgsig_bench
